// [uart_flags_consts.svh]
// Register offsets, bit positions and reset values of the serial flag block
`ifndef UART_FLAGS_CONSTS_SVH
`define UART_FLAGS_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_STATUS_ONE   3'h0
`define OFS_CTRL_ONE     3'h1
`define OFS_CTRL_TWO     3'h2
`define OFS_CTRL_THREE   3'h3
`define OFS_DATA         3'h7

// ****************************************
// Control register one bits
// ****************************************
`define BIT_LOOP_SELECT  7
`define BIT_RECEIVER_SOURCE_SELECT_SELECT  5
`define BIT_NINE_BIT     4

// ****************************************
// Control register two bits
// ****************************************
`define BIT_TIE          7
`define BIT_TX_COMPLETE_IRQ_ENABLE         6
`define BIT_RIE          5
`define BIT_ILIE         4
`define BIT_RX_SLEEP     1

// ****************************************
// Control register three bits
// ****************************************
`define BIT_RX_NINTH     7
`define BIT_TX_NINTH     6
`define BIT_TX_DIR       5
`define BIT_ORIE         3
`define BIT_NEIE         2
`define BIT_FEIE         1
`define BIT_PEIE         0

// ****************************************
// Reset values
// ****************************************
`define RST_STATUS       8'hc0
`define RST_BYTE         8'h00
`define RST_SHIFT        9'h1ff

`endif

// [uart_flags_pkg.sv]
// Types shared by the serial flag block and its pin multiplexer
package uart_flags_pkg;

   // Status flags in status register bit order, msb first
   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic tx_complete_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_error_flag;
      logic parity_error_flag;
   } status_t;

   // One received character handed over by the receive shifter
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       ninth;
      logic       noise;
      logic       framing;
      logic       parity;
   } rx_char_t;

   // Routing of the receiver input
   typedef enum logic [1:0] {
      ROUTE_NORMAL,
      ROUTE_LOOP,
      ROUTE_SINGLE
   } route_t;

endpackage

// [serial_pin_mux.sv]
// Pin routing for normal, internal loop and single-wire modes
`timescale 1ns/1ns
`default_nettype none

module serial_pin_mux
   import uart_flags_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Mode controls
   input  wire logic loop_select,
   input  wire logic receiver_source_select,
   input  wire logic single_wire_direction,
   // Transmitter and receiver side
   input  wire logic tx_serial,
   output var  logic rx_serial,
   // Pins
   input  wire logic serial_in_pin_in,
   input  wire logic serial_out_pin_in,
   output var  logic serial_out_pin_out,
   output var  logic serial_out_pin_oe,
   output var  logic serial_in_release
);

   route_t route;

   // Mode decode from the two select bits
   always_comb begin
      if (!loop_select) begin
         route = ROUTE_NORMAL;
      end else if (receiver_source_select) begin
         route = ROUTE_SINGLE;
      end else begin
         route = ROUTE_LOOP;
      end
   end

   // Registered routing; idle line is high, so reset drives high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_serial          <= 1'b1;
         serial_out_pin_out <= 1'b1;
         serial_out_pin_oe  <= 1'b1;
         serial_in_release  <= 1'b0;
      end else begin
         serial_out_pin_out <= tx_serial;
         serial_in_release  <= loop_select;
         case (route)
            ROUTE_NORMAL: begin
               rx_serial         <= serial_in_pin_in;
               serial_out_pin_oe <= 1'b1;
            end
            ROUTE_LOOP: begin
               rx_serial         <= tx_serial;
               serial_out_pin_oe <= 1'b1;
            end
            ROUTE_SINGLE: begin
               // Own transmissions come straight from tx_serial; with direction clear the shared wire feeds the receiver
               rx_serial         <= single_wire_direction ? tx_serial
                                                          : serial_out_pin_in;
               serial_out_pin_oe <= single_wire_direction;
            end
            default: begin
               rx_serial         <= serial_in_pin_in;
               serial_out_pin_oe <= 1'b1;
            end
         endcase
      end
   end

endmodule // serial_pin_mux

`default_nettype wire

// [uart_flags.sv]
// Status flags, interrupt grouping, 9-bit data, stop and loop modes of a UART
// Contract
// - Three requests: transmit, receive, error group
// - Eight local masks; flags still set when masked
// - Buffer empty flag requests while enable set
// - Complete flag set when all sent, idle
// - Full flag clears by status then data read
// - Idle clears likewise; rearms after new character
// - Error flags set with full flag, not overrun
// - Overrun when full; new character discarded
// - Nine-bit mode uses ninth bits register three
// - Ninth bit copied at shifter load, kept
// - Stop halts; deep stops lose, stop3 keeps
// - Loop select plus source picks mode
// - Loop mode feeds transmitter to receiver internally
// - Single-wire joins receiver, transmitter, output pin
// - Direction bit enables transmitter onto pin
// - Single-wire receiver hears own transmissions
// - Character moves to buffer only when empty
// - Receiver sleep suppresses all receive flags
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "uart_flags_consts.svh"

module uart_flags
   import uart_flags_pkg::*;
#(
   parameter int ADDR_W = 3,
   parameter int DATA_W = 8
)(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [DATA_W-1:0] reg_rdata,
   // Stop mode: deep means stop1 or stop2
   input  wire logic              stop_active,
   input  wire logic              stop_deep,
   // Transmit shifter side
   input  wire logic              tx_load,
   input  wire logic              tx_done,
   input  wire logic              tx_serial,
   output var  logic [8:0]        tx_shift_word,
   output var  logic              tx_buf_empty,
   output var  logic              nine_bit_mode,
   // Receive shifter side
   input  wire rx_char_t          rx_char,
   input  wire logic              rx_idle_detect,
   input  wire logic              rx_wakeup,
   output var  logic              rx_serial,
   output var  logic              rx_sleep,
   // Interrupt requests
   output var  logic              irq_tx,
   output var  logic              irq_rx,
   output var  logic              irq_err,
   // Pins
   input  wire logic              serial_in_pin_in,
   input  wire logic              serial_out_pin_in,
   output var  logic              serial_out_pin_out,
   output var  logic              serial_out_pin_oe,
   output var  logic              serial_in_release
);

   // ****************************************
   // Parameter check
   // ****************************************
   if (ADDR_W != 3 || DATA_W != 8) begin : g_bad_param
      $error("uart_flags supports only ADDR_W 3 and DATA_W 8");
   end

   // ****************************************
   // State
   // ****************************************
   // Flag reset image, the same value a status read shows after reset
   localparam status_t RST_FLAGS = `RST_STATUS;
   status_t     status;
   status_t     clear_mask;
   logic [7:0]  ctrl_one;
   logic [7:0]  ctrl_two;
   logic [7:0]  ctrl_three;
   logic [7:0]  tx_buf;
   logic [7:0]  rx_buf;
   logic        idle_allowed;
   logic        rst_all;
   logic        run;
   logic        wr_ok;
   logic        rd_ok;
   logic        rd_status;
   logic        rd_data;
   logic        wr_data;
   logic        clr_rx_full;
   logic        clr_idle;
   logic        rx_accept;
   logic        rx_overrun;
   logic        idle_set;
   logic        next_irq_tx;
   logic        next_irq_rx;
   logic        next_irq_err;

   // ****************************************
   // Stop handling and bus decode
   // ****************************************
   // Deep stop loses all state; stop3 freezes it for resumption
   assign rst_all   = sys_rst | (stop_active & stop_deep);
   assign run       = !stop_active;
   assign wr_ok     = run & reg_wr;
   assign rd_ok     = run & reg_rd;
   assign rd_status = rd_ok & (reg_addr == `OFS_STATUS_ONE);
   assign rd_data   = rd_ok & (reg_addr == `OFS_DATA);
   // Writes while the buffer is still full are refused
   assign wr_data   = wr_ok & (reg_addr == `OFS_DATA) & status.tx_buffer_empty_flag;

   // Flags seen set at the status read are the only ones a data read clears
   assign clr_rx_full = rd_data & clear_mask.rx_full_flag;
   assign clr_idle    = rd_data & clear_mask.idle_flag;

   // Sleeping receiver drops characters without touching any flag
   assign rx_accept  = run & rx_char.valid & !ctrl_two[`BIT_RX_SLEEP]
                     & (!status.rx_full_flag | clr_rx_full);
   assign rx_overrun = run & rx_char.valid & !ctrl_two[`BIT_RX_SLEEP]
                     & status.rx_full_flag & !clr_rx_full;
   assign idle_set   = run & rx_idle_detect & !ctrl_two[`BIT_RX_SLEEP]
                     & idle_allowed;

   // ****************************************
   // Control registers
   // ****************************************
   // Control register one: mode selects
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         ctrl_one <= `RST_BYTE;
      end else if (wr_ok && reg_addr == `OFS_CTRL_ONE) begin
         ctrl_one <= reg_wdata;
      end
   end

   // Control register two: enables and receiver sleep
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         ctrl_two <= `RST_BYTE;
      end else if (wr_ok && reg_addr == `OFS_CTRL_TWO) begin
         ctrl_two <= reg_wdata;  // A write beats a same-cycle wakeup
      end else if (run && rx_wakeup) begin
         ctrl_two[`BIT_RX_SLEEP] <= 1'b0;
      end
   end

   // Control register three; received ninth bit is hardware-owned
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         ctrl_three <= `RST_BYTE;
      end else begin
         if (wr_ok && reg_addr == `OFS_CTRL_THREE) begin
            ctrl_three[`BIT_TX_NINTH] <= reg_wdata[`BIT_TX_NINTH];
            ctrl_three[`BIT_TX_DIR]   <= reg_wdata[`BIT_TX_DIR];
            ctrl_three[`BIT_ORIE]     <= reg_wdata[`BIT_ORIE];
            ctrl_three[`BIT_NEIE]     <= reg_wdata[`BIT_NEIE];
            ctrl_three[`BIT_FEIE]     <= reg_wdata[`BIT_FEIE];
            ctrl_three[`BIT_PEIE]     <= reg_wdata[`BIT_PEIE];
         end
         if (rx_accept) begin
            ctrl_three[`BIT_RX_NINTH] <= ctrl_one[`BIT_NINE_BIT] & rx_char.ninth;
         end
      end
   end

   // ****************************************
   // Transmit path
   // ****************************************
   // Buffer byte, written only into an empty buffer
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         tx_buf <= `RST_BYTE;
      end else if (wr_data) begin
         tx_buf <= reg_wdata;
      end
   end

   // Shifter word: ninth bit copied in the same cycle as the byte
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         tx_shift_word <= `RST_SHIFT;
      end else if (run && tx_load && !status.tx_buffer_empty_flag) begin
         tx_shift_word <= {ctrl_one[`BIT_NINE_BIT] & ctrl_three[`BIT_TX_NINTH],
                           tx_buf};
      end
   end

   // Empty flag: write claims the buffer, shifter load frees it
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.tx_buffer_empty_flag <= RST_FLAGS.tx_buffer_empty_flag;
      end else if (run && tx_load && !status.tx_buffer_empty_flag) begin
         status.tx_buffer_empty_flag <= 1'b1;
      end else if (wr_data) begin
         status.tx_buffer_empty_flag <= 1'b0;
      end
   end

   // Complete flag: a same-cycle data write means more to send, so it wins
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.tx_complete_flag <= RST_FLAGS.tx_complete_flag;
      end else if (run && tx_done && status.tx_buffer_empty_flag && !wr_data) begin
         status.tx_complete_flag <= 1'b1;
      end else if (wr_data) begin
         status.tx_complete_flag <= 1'b0;
      end
   end

   // ****************************************
   // Receive path
   // ****************************************
   // Receive buffer takes a character only when accepted
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         rx_buf <= `RST_BYTE;
      end else if (rx_accept) begin
         rx_buf <= rx_char.data;
      end
   end

   // Snapshot of flags at the status read arms the clearing read
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         clear_mask <= '0;
      end else if (rd_status) begin
         clear_mask <= status;
      end else if (rd_data) begin
         clear_mask <= '0;
      end
   end

   // Full flag; a character arriving on the clearing read is kept
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.rx_full_flag <= 1'b0;
      end else if (rx_accept) begin
         status.rx_full_flag <= 1'b1;
      end else if (clr_rx_full) begin
         status.rx_full_flag <= 1'b0;
      end
   end

   // Error flags travel with the accepted character only
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.noise_flag         <= 1'b0;
         status.framing_error_flag <= 1'b0;
         status.parity_error_flag  <= 1'b0;
      end else if (rx_accept) begin
         status.noise_flag         <= rx_char.noise;
         status.framing_error_flag <= rx_char.framing;
         status.parity_error_flag  <= rx_char.parity;
      end else if (rd_data) begin
         status.noise_flag         <= status.noise_flag & !clear_mask.noise_flag;
         status.framing_error_flag <= status.framing_error_flag
                                      & !clear_mask.framing_error_flag;
         status.parity_error_flag  <= status.parity_error_flag
                                      & !clear_mask.parity_error_flag;
      end
   end

   // Overrun: the new character and its error conditions are dropped
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.overrun_flag <= 1'b0;
      end else if (rx_overrun) begin
         status.overrun_flag <= 1'b1;
      end else if (rd_data && clear_mask.overrun_flag) begin
         status.overrun_flag <= 1'b0;
      end
   end

   // Idle flag; set wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         status.idle_flag <= 1'b0;
      end else if (idle_set) begin
         status.idle_flag <= 1'b1;
      end else if (clr_idle) begin
         status.idle_flag <= 1'b0;
      end
   end

   // Long idle lines must not retrigger: rearm only on a new character
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         idle_allowed <= 1'b1;
      end else if (rx_accept) begin
         idle_allowed <= 1'b1;
      end else if (clr_idle) begin
         idle_allowed <= 1'b0;
      end
   end

   // ****************************************
   // Interrupt requests
   // ****************************************
   // Masks gate only the request, never the flag
   always_comb begin
      next_irq_tx  = (status.tx_buffer_empty_flag & ctrl_two[`BIT_TIE])
                   | (status.tx_complete_flag & ctrl_two[`BIT_TX_COMPLETE_IRQ_ENABLE]);
      next_irq_rx  = (status.rx_full_flag & ctrl_two[`BIT_RIE])
                   | (status.idle_flag & ctrl_two[`BIT_ILIE]);
      next_irq_err = (status.overrun_flag & ctrl_three[`BIT_ORIE])
                   | (status.noise_flag & ctrl_three[`BIT_NEIE])
                   | (status.framing_error_flag & ctrl_three[`BIT_FEIE])
                   | (status.parity_error_flag & ctrl_three[`BIT_PEIE]);
   end

   // Registered requests, one cycle behind the flags
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         irq_tx  <= 1'b0;
         irq_rx  <= 1'b0;
         irq_err <= 1'b0;
      end else if (run) begin
         irq_tx  <= next_irq_tx;
         irq_rx  <= next_irq_rx;
         irq_err <= next_irq_err;
      end
   end

   // ****************************************
   // Read port and shifter-side copies
   // ****************************************
   // Read data stand for one cycle after the strobe, else zero
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         reg_rdata <= `RST_BYTE;
      end else if (rd_ok) begin
         case (reg_addr)
            `OFS_STATUS_ONE: reg_rdata <= status;
            `OFS_CTRL_ONE:   reg_rdata <= ctrl_one;
            `OFS_CTRL_TWO:   reg_rdata <= ctrl_two;
            `OFS_CTRL_THREE: reg_rdata <= ctrl_three;
            `OFS_DATA:       reg_rdata <= rx_buf;
            default:         reg_rdata <= `RST_BYTE;
         endcase
      end else begin
         reg_rdata <= `RST_BYTE;
      end
   end

   // Flop copies for the shifters
   always_ff @(posedge clk_sys) begin
      if (rst_all) begin
         tx_buf_empty  <= 1'b1;
         nine_bit_mode <= 1'b0;
         rx_sleep      <= 1'b0;
      end else begin
         tx_buf_empty  <= status.tx_buffer_empty_flag;
         nine_bit_mode <= ctrl_one[`BIT_NINE_BIT];
         rx_sleep      <= ctrl_two[`BIT_RX_SLEEP];
      end
   end

   // ****************************************
   // Pin routing
   // ****************************************
   serial_pin_mux u_pin_mux (
      .clk_sys                (clk_sys),
      .rst                    (rst_all),
      .loop_select            (ctrl_one[`BIT_LOOP_SELECT]),
      .receiver_source_select (ctrl_one[`BIT_RECEIVER_SOURCE_SELECT_SELECT]),
      .single_wire_direction  (ctrl_three[`BIT_TX_DIR]),
      .tx_serial              (tx_serial),
      .rx_serial              (rx_serial),
      .serial_in_pin_in       (serial_in_pin_in),
      .serial_out_pin_in      (serial_out_pin_in),
      .serial_out_pin_out     (serial_out_pin_out),
      .serial_out_pin_oe      (serial_out_pin_oe),
      .serial_in_release      (serial_in_release)
   );

endmodule // uart_flags

`default_nettype wire

// [uart_flags_chk.sv]
// Port-level assertions for the serial flag block
`timescale 1ns/1ns
`default_nettype none

module uart_flags_chk
   import uart_flags_pkg::*;
#(
   parameter int DATA_W = 8
)(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DATA_W-1:0] reg_rdata,
   // Stop and shifter side
   input  wire logic              stop_active,
   input  wire logic              stop_deep,
   input  wire logic              tx_load,
   input  wire logic              tx_done,
   input  wire logic [8:0]        tx_shift_word,
   input  wire logic              tx_buf_empty,
   input  wire rx_char_t          rx_char,
   input  wire logic              rx_idle_detect,
   // Requests
   input  wire logic              irq_tx,
   input  wire logic              irq_rx,
   input  wire logic              irq_err
);
   // ********
   // Assertions
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // A load that finds a character; the empty copy lags the flag by one
   sequence seq_load_taken;
      tx_load && !tx_buf_empty && !reg_wr && !stop_active;
   endsequence
   sequence seq_empty_shown;
      ##2 tx_buf_empty;
   endsequence

   chk_load_empties: assert property (seq_load_taken |-> seq_empty_shown)
      else $error("empty flag not raised after load");
   chk_word_holds: assert property (!tx_load && !(stop_active && stop_deep) |=> $stable(tx_shift_word))
      else $error("shift word changed without load");
   chk_stop3_hold: assert property (stop_active && !stop_deep && $past(stop_active) && !$past(stop_deep)
      |=> $stable(tx_shift_word) && $stable(tx_buf_empty) && $stable(irq_rx) && $stable(irq_err))
      else $error("state moved in light stop");
   chk_deep_reset: assert property (stop_active && stop_deep
      |=> tx_shift_word == 9'h1ff && tx_buf_empty && !irq_tx && !irq_rx && !irq_err)
      else $error("deep stop did not reset");
   chk_rd_stop: assert property (reg_rd && stop_active |=> reg_rdata == '0)
      else $error("read answered in stop");
   chk_err_cause: assert property ($rose(irq_err) |-> $past(rx_char.valid, 2) || $past(reg_wr, 2))
      else $error("error request without cause");
   chk_rx_cause: assert property ($rose(irq_rx)
      |-> $past(rx_char.valid, 2) || $past(rx_idle_detect, 2) || $past(reg_wr, 2))
      else $error("receive request without cause");
   chk_tx_cause: assert property ($rose(irq_tx)
      |-> $past(tx_load, 2) || $past(tx_done, 2) || $past(reg_wr, 2))
      else $error("transmit request without cause");
endmodule // uart_flags_chk

`default_nettype wire

// [tx_peer.sv]
// Transmit shifter stand-in: takes the buffer and finishes each frame
`timescale 1ns/1ns
`default_nettype none

module tx_peer (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // Buffer state and hold-off
   input  wire logic tx_buf_empty,
   input  wire logic stall,
   // Shifter strobes
   output var  logic tx_load,
   output var  logic tx_done
);
   logic [3:0] busy_cnt;

   // Frame lasts eight cycles; the gap covers the lag of the empty copy
   always_ff @(posedge clk_sys) begin
      tx_load <= 1'b0;
      tx_done <= 1'b0;
      if (sys_rst)
         busy_cnt <= 4'h0;
      else if (busy_cnt != 4'h0) begin
         busy_cnt <= busy_cnt - 4'h1;
         tx_done  <= (busy_cnt == 4'h1);
      end else if (!tx_buf_empty && !stall) begin
         tx_load  <= 1'b1;
         busy_cnt <= 4'h8;
      end
   end
endmodule // tx_peer

`default_nettype wire

// [async_serial_flags_and_modes_test.sv]
// Self-checking bench for the serial flag block
`timescale 1ns/1ns
`default_nettype none

module async_serial_flags_and_modes_test import uart_flags_pkg::*;;
   logic       clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b1, ext = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic       stop_active = 1'b0, stop_deep = 1'b0, tx_load, tx_done, tx_serial = 1'b1, e;
   logic [8:0] tx_shift_word;
   logic       tx_buf_empty, nine_bit_mode, rx_idle_detect = 1'b0, rx_wakeup = 1'b0, rx_sleep;
   logic       rx_serial, irq_tx, irq_rx, irq_err, serial_in_pin_in = 1'b1, serial_out_pin_in;
   logic       serial_out_pin_out, serial_out_pin_oe, serial_in_release;
   rx_char_t   rx_char = '0;
   int         fails = 0, n_checks = 0;
   logic [7:0] m1 [4] = '{8'h00, 8'h80, 8'ha0, 8'ha0};
   logic [7:0] m3 [4] = '{8'h00, 8'h00, 8'h00, 8'h20};

   // 25 MHz bus clock
   always #20 clk_sys = ~clk_sys;
   // Line is pulled high; the outside party drives ext while the pin is released
   assign serial_out_pin_in = serial_out_pin_oe ? serial_out_pin_out : ext;

   uart_flags DUT (.*);
   tx_peer PEER (.*);

   // ********
   // Access tasks
   // ********
   task automatic chk(input logic [8:0] g, input logic [8:0] x);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, x);
   endtask
   // Character as {data, ninth, noise, framing, parity}
   task automatic rxc(input logic [11:0] v);
      @(posedge clk_sys);
      rx_char <= {1'b1, v};
      @(posedge clk_sys);
      rx_char <= {1'b0, v};
   endtask
   task automatic pls(input logic [1:0] k);
      @(posedge clk_sys);
      {rx_wakeup, rx_idle_detect} <= k;
      @(posedge clk_sys);
      {rx_wakeup, rx_idle_detect} <= 2'b00;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog: the run needs well under 2000 cycles
   initial begin
      #(40 * 4000);
      fails++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(3'h0, 8'hc0);
      rd(3'h2, 8'h00);
      rd(3'h4, 8'h00);
      chk({irq_tx, irq_rx, irq_err}, 9'h0);
      // Nine-bit transmit, ninth bit written first and then reused
      wr(3'h3, 8'h40);
      wr(3'h1, 8'h10);
      wr(3'h7, 8'ha5);
      rd(3'h0, 8'h00);
      chk(tx_shift_word, 9'h1ff);
      chk(tx_buf_empty, 1'b0);
      @(posedge clk_sys) stall <= 1'b0;
      idle(16);
      chk(tx_shift_word, 9'h1a5);
      chk(nine_bit_mode, 1'b1);
      chk(tx_buf_empty, 1'b1);
      wr(3'h7, 8'h3c);
      idle(16);
      chk(tx_shift_word, 9'h13c);
      rd(3'h0, 8'hc0);
      wr(3'h2, 8'hc0);
      idle(2);
      chk(irq_tx, 1'b1);
      wr(3'h2, 8'h40);
      idle(2);
      chk(irq_tx, 1'b1);
      wr(3'h2, 8'h00);
      idle(2);
      chk(irq_tx, 1'b0);
      rd(3'h0, 8'hc0);
      // Error flags with the character, overrun drops the next one
      wr(3'h3, 8'h44);
      wr(3'h2, 8'h20);
      rxc(12'h5ac);
      idle(2);
      chk({irq_tx, irq_rx, irq_err}, 9'h3);
      rd(3'h0, 8'he4);
      rd(3'h3, 8'hc4);
      rxc(12'h992);
      rd(3'h0, 8'hec);
      rd(3'h7, 8'h5a);
      rd(3'h0, 8'hc0);
      idle(2);
      chk({irq_rx, irq_err}, 9'h0);
      // Data read alone leaves the buffer full
      rxc(12'h110);
      rd(3'h7, 8'h11);
      rd(3'h0, 8'he0);
      rd(3'h7, 8'h11);
      rd(3'h0, 8'hc0);
      // Idle does not rearm until a new character
      rxc(12'h220);
      pls(2'b01);
      rd(3'h0, 8'hf0);
      rd(3'h7, 8'h22);
      rd(3'h0, 8'hc0);
      pls(2'b01);
      rd(3'h0, 8'hc0);
      rxc(12'h330);
      pls(2'b01);
      rd(3'h0, 8'hf0);
      rd(3'h7, 8'h33);
      // Sleep hides characters until the wakeup
      wr(3'h2, 8'h02);
      idle(3);
      chk(rx_sleep, 1'b1);
      rxc(12'h440);
      pls(2'b01);
      rd(3'h0, 8'hc0);
      pls(2'b10);
      idle(2);
      chk(rx_sleep, 1'b0);
      rxc(12'h553);
      rd(3'h0, 8'he3);
      // Light stop keeps state, deep stop clears it; entered with both shifters quiet
      @(posedge clk_sys) stop_active <= 1'b1;
      rd(3'h0, 8'h00);
      @(posedge clk_sys) stop_active <= 1'b0;
      rd(3'h0, 8'he3);
      @(posedge clk_sys) {stop_active, stop_deep} <= 2'b11;
      idle(2);
      @(posedge clk_sys) {stop_active, stop_deep} <= 2'b00;
      rd(3'h0, 8'hc0);
      rd(3'h1, 8'h00);
      // Normal, loop, single-wire input and single-wire output routing
      for (int i = 0; i < 4; i++) begin
         wr(3'h1, m1[i]);
         wr(3'h3, m3[i]);
         for (int j = 0; j < 4; j++) begin
            @(posedge clk_sys);
            tx_serial        <= j[0];
            serial_in_pin_in <= j[1];
            ext              <= !j[0];
            idle(3);
            e = (i == 0) ? j[1] : (i == 2) ? !j[0] : j[0];
            chk(rx_serial, e);
            chk(serial_in_release, i > 0);
            chk(serial_out_pin_oe, i != 2);
            if (i != 2)
               chk(serial_out_pin_out, j[0]);
         end
      end
      report_and_stop();
   end
endmodule // async_serial_flags_and_modes_test

bind uart_flags uart_flags_chk #(.DATA_W(DATA_W)) CHK (.*);

`default_nettype wire
